// >>> dbg_pkg.sv
// shared constants and types for the debug and trace port logic
package dbg_pkg;
   localparam int unsigned clock_hz        = 50000000;
   // power-on hold of the debug logic reset, in processor cycles
   localparam int unsigned por_cycles      = 4;
   localparam int unsigned por_width       = 3;
   // on-demand test reset hold: 2.5 master clock periods, rounded up
   localparam int unsigned trst_half_periods = 5;
   localparam int unsigned trst_cycles     = (trst_half_periods + 1) / 2;
   localparam int unsigned trst_width      = 2;
   localparam int unsigned status_width    = 3;
   localparam int unsigned packet_width    = 8;
   localparam int unsigned packets_per_cyc = 2;
   localparam int unsigned port_width      = packet_width * packets_per_cyc;
   localparam int unsigned ir_width        = 4;
   localparam int unsigned chain_count     = 2;
   localparam int unsigned chain_width     = 32;
   localparam int unsigned bsr_width       = 16;
   // instruction codes of the test access port
   localparam logic [3:0] ir_extest        = 4'h0;
   localparam logic [3:0] ir_sample        = 4'h3;
   localparam logic [3:0] ir_scan_n        = 4'h2;
   localparam logic [3:0] ir_intest        = 4'hc;
   localparam logic [3:0] ir_bypass        = 4'hf;
   localparam logic [3:0] ir_reset_value   = 4'hf;
   // pipeline status codes that carry no packet payload
   localparam logic [2:0] ps_cond_fail     = 3'h3;
   localparam logic [2:0] ps_wait          = 3'h6;
   localparam logic [2:0] ps_idle          = 3'h0;
   typedef enum {
      tap_reset, tap_idle, tap_sel_dr, tap_cap_dr, tap_sh_dr, tap_ex1_dr,
      tap_pause_dr, tap_ex2_dr, tap_upd_dr, tap_sel_ir, tap_cap_ir, tap_sh_ir,
      tap_ex1_ir, tap_pause_ir, tap_ex2_ir, tap_upd_ir
   } tap_state_t;
endpackage : dbg_pkg

// >>> debug_trace_port_access.sv
// debug access: test access port with emulation and boundary scan, plus trace
// Contract
// [R1] scan_mode_select low routes the test port to emulation logic.
// [R2] mode select is latched only at chip reset; no live switchover.
// [R3] debug logic reset is generated internally at power-up.
// [R4] outside reset request holds debug_logic_reset_n low 2.5 master clocks.
// [R5] test clock at most one sixth processor clock unless paced by return.
// [R6] returned test clock driven only in emulation mode.
// [R7] test data out shifts the selected register toward the next device.
// [R8] two internal scan chains carry instructions in and results out.
// [R9] trace clock is the processor clock divided by two.
// [R10] trace_sync marks start of a branch sequence on packets.
// [R11] pipeline status shows processor state each trace edge.
// [R12] two 8-bit packets per trace cycle on 16 lines.
// [R13] payload-free states give status only, packet lines zero.
// [R14] trace unit has comparators, counters, sequencer, fifo as listed; trace_port has none of them, only registers status and packets.
// [R15] trace unit external inputs and outputs stay unconnected.
// [R16] scan_mode_select high gives boundary scan: sample, extest, bypass.
// [R17] trace data presented on both trace clock edges.
// [R18] trace outputs registered in processor domain, aligned with trace clock.
module debug_trace_port_access (
   input  wire logic                                clock,
   input  wire logic                                rst,
   input  wire logic                                scan_mode_select,
   input  wire logic                                debug_logic_reset_n,
   input  wire logic                                tck,
   input  wire logic                                tms,
   input  wire logic                                tdi,
   output logic                                     tdo,
   output logic                                     tdo_oe,
   output logic                                     returned_test_clock,
   input  wire logic [dbg_pkg::bsr_width-1:0]       pin_sample,
   output logic [dbg_pkg::bsr_width-1:0]            pin_force,
   output logic                                     pin_force_en,
   input  wire logic [dbg_pkg::chain_width-1:0]     core_result,
   output logic [dbg_pkg::chain_width-1:0]          core_instr,
   output logic                                     core_instr_valid,
   input  wire logic [dbg_pkg::status_width-1:0]    core_status,
   input  wire logic [dbg_pkg::port_width-1:0]      core_packet,
   input  wire logic [dbg_pkg::packets_per_cyc-1:0] core_packet_valid,
   input  wire logic                                core_branch_start,
   output logic                                     debug_reset,
   output logic                                     emulation_mode,
   output logic                                     trace_clock,
   output logic                                     trace_sync,
   output logic [dbg_pkg::status_width-1:0]         pipeline_status,
   output logic [dbg_pkg::port_width-1:0]           trace_packet
);
   logic                                 tck_s;
   logic                                 tms_s;
   logic                                 tdi_s;
   logic                                 trst_n_s;
   logic                                 sel_s;
   logic                                 tck_prev;
   logic                                 tck_rise;
   logic                                 tck_fall;
   logic [dbg_pkg::por_width-1:0]        por_count;
   logic [dbg_pkg::trst_width-1:0]       trst_count;
   logic                                 trst_hit;
   dbg_pkg::tap_state_t                  tap;
   dbg_pkg::tap_state_t                  next_tap;
   logic [dbg_pkg::ir_width-1:0]         ir_shift;
   logic [dbg_pkg::ir_width-1:0]         ir;
   logic                                 bypass_bit;
   logic [dbg_pkg::bsr_width-1:0]        bsr;
   logic [dbg_pkg::chain_width-1:0]      chain [dbg_pkg::chain_count];
   logic                                 chain_sel;
   logic                                 scan_out;
   logic                                 unused_trace_io;
   logic                                 trace_edge;

   // pins come from the probe clock domain: synchronise all of them
   sync2 u_tck (.clock(clock), .rst(rst), .d(tck), .q(tck_s));
   sync2 u_tms (.clock(clock), .rst(rst), .d(tms), .q(tms_s));
   sync2 u_tdi (.clock(clock), .rst(rst), .d(tdi), .q(tdi_s));
   sync2 #(.init(1'b1)) u_trst (.clock(clock), .rst(rst), .d(debug_logic_reset_n),
      .q(trst_n_s));
   sync2 u_sel (.clock(clock), .rst(rst), .d(scan_mode_select), .q(sel_s));

   // oversampled test clock; needs tck well below clock rate
   always_ff @(posedge clock)
   begin
      if (rst)
         tck_prev <= 1'b0;
      else
         tck_prev <= tck_s; // R5
   end
   assign tck_rise = tck_s & ~tck_prev;
   assign tck_fall = ~tck_s & tck_prev;

   // power-on counter keeps debug reset asserted after chip reset
   always_ff @(posedge clock)
   begin
      if (rst)
         por_count <= '0;
      else if (por_count != dbg_pkg::por_width'(dbg_pkg::por_cycles))
         por_count <= por_count + 1'b1; // R3
   end

   // on-demand reset only counts once held for the full time
   always_ff @(posedge clock)
   begin
      if (rst || trst_n_s)
         trst_count <= '0;
      else if (!trst_hit)
         trst_count <= trst_count + 1'b1; // R4
   end
   assign trst_hit = (trst_count == dbg_pkg::trst_width'(dbg_pkg::trst_cycles));
   assign debug_reset = (por_count != dbg_pkg::por_width'(dbg_pkg::por_cycles)) ||
                        trst_hit; // R3 R4

   // mode captured only while the power-on hold after chip reset runs; chip reset itself loads emulation
   always_ff @(posedge clock)
   begin
      if (rst)
         emulation_mode <= 1'b1;
      else if (por_count != dbg_pkg::por_width'(dbg_pkg::por_cycles))
         emulation_mode <= ~sel_s; // R1 R2 R16
   end

   // test state machine advances on each test clock rise
   always_comb
   begin
      next_tap = tap;
      case (tap)
         dbg_pkg::tap_reset:    next_tap = tms_s ? dbg_pkg::tap_reset  : dbg_pkg::tap_idle;
         dbg_pkg::tap_idle:     next_tap = tms_s ? dbg_pkg::tap_sel_dr : dbg_pkg::tap_idle;
         dbg_pkg::tap_sel_dr:   next_tap = tms_s ? dbg_pkg::tap_sel_ir : dbg_pkg::tap_cap_dr;
         dbg_pkg::tap_cap_dr:   next_tap = tms_s ? dbg_pkg::tap_ex1_dr : dbg_pkg::tap_sh_dr;
         dbg_pkg::tap_sh_dr:    next_tap = tms_s ? dbg_pkg::tap_ex1_dr : dbg_pkg::tap_sh_dr;
         dbg_pkg::tap_ex1_dr:   next_tap = tms_s ? dbg_pkg::tap_upd_dr : dbg_pkg::tap_pause_dr;
         dbg_pkg::tap_pause_dr: next_tap = tms_s ? dbg_pkg::tap_ex2_dr : dbg_pkg::tap_pause_dr;
         dbg_pkg::tap_ex2_dr:   next_tap = tms_s ? dbg_pkg::tap_upd_dr : dbg_pkg::tap_sh_dr;
         dbg_pkg::tap_upd_dr:   next_tap = tms_s ? dbg_pkg::tap_sel_dr : dbg_pkg::tap_idle;
         dbg_pkg::tap_sel_ir:   next_tap = tms_s ? dbg_pkg::tap_reset  : dbg_pkg::tap_cap_ir;
         dbg_pkg::tap_cap_ir:   next_tap = tms_s ? dbg_pkg::tap_ex1_ir : dbg_pkg::tap_sh_ir;
         dbg_pkg::tap_sh_ir:    next_tap = tms_s ? dbg_pkg::tap_ex1_ir : dbg_pkg::tap_sh_ir;
         dbg_pkg::tap_ex1_ir:   next_tap = tms_s ? dbg_pkg::tap_upd_ir : dbg_pkg::tap_pause_ir;
         dbg_pkg::tap_pause_ir: next_tap = tms_s ? dbg_pkg::tap_ex2_ir : dbg_pkg::tap_pause_ir;
         dbg_pkg::tap_ex2_ir:   next_tap = tms_s ? dbg_pkg::tap_upd_ir : dbg_pkg::tap_sh_ir;
         dbg_pkg::tap_upd_ir:   next_tap = tms_s ? dbg_pkg::tap_sel_dr : dbg_pkg::tap_idle;
         default:               next_tap = dbg_pkg::tap_reset;
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (rst || debug_reset)
         tap <= dbg_pkg::tap_reset;
      else if (tck_rise)
         tap <= next_tap;
   end

   // instruction register: capture, shift, update
   always_ff @(posedge clock)
   begin
      if (rst || debug_reset || tap == dbg_pkg::tap_reset)
      begin
         ir_shift <= dbg_pkg::ir_reset_value;
         ir       <= dbg_pkg::ir_reset_value;
      end
      else if (tck_rise)
      begin
         if (tap == dbg_pkg::tap_cap_ir)
            ir_shift <= ir;
         else if (tap == dbg_pkg::tap_sh_ir)
            ir_shift <= {tdi_s, ir_shift[dbg_pkg::ir_width-1:1]};
         else if (tap == dbg_pkg::tap_upd_ir)
            ir <= ir_shift;
      end
   end

   // boundary register: sample captures pins, extest forces them
   always_ff @(posedge clock)
   begin
      if (rst || debug_reset)
      begin
         bsr        <= '0;
         pin_force  <= '0;
      end
      else if (tck_rise && !emulation_mode)
      begin
         if (tap == dbg_pkg::tap_cap_dr)
            bsr <= pin_sample; // R16
         else if (tap == dbg_pkg::tap_sh_dr)
         begin
            if (ir == dbg_pkg::ir_sample || ir == dbg_pkg::ir_extest)
               bsr <= {tdi_s, bsr[dbg_pkg::bsr_width-1:1]};
         end
         else if (tap == dbg_pkg::tap_upd_dr && ir == dbg_pkg::ir_extest)
            pin_force <= bsr; // R16
      end
   end
   assign pin_force_en = !emulation_mode && (ir == dbg_pkg::ir_extest); // R16

   // bypass stage serves both modes: ir resets to bypass in emulation too
   always_ff @(posedge clock)
   begin
      if (rst || debug_reset)
         bypass_bit <= 1'b0;
      else if (tck_rise && tap == dbg_pkg::tap_cap_dr)
         bypass_bit <= 1'b0;
      else if (tck_rise && tap == dbg_pkg::tap_sh_dr)
         bypass_bit <= tdi_s; // R7 R16
   end

   // chain select loaded through the scan-select instruction
   always_ff @(posedge clock)
   begin
      if (rst || debug_reset)
         chain_sel <= 1'b0;
      else if (tck_rise && emulation_mode && tap == dbg_pkg::tap_upd_dr &&
               ir == dbg_pkg::ir_scan_n)
         chain_sel <= chain[0][0]; // R8
   end

   // two internal chains: capture core result, shift, hand instruction in
   generate
      for (genvar c = 0; c < int'(dbg_pkg::chain_count); c++)
      begin : g_chain
         always_ff @(posedge clock)
         begin
            if (rst || debug_reset)
               chain[c] <= '0;
            else if (tck_rise && emulation_mode && chain_sel == 1'(c))
            begin
               if (tap == dbg_pkg::tap_cap_dr)
                  chain[c] <= core_result; // R8
               else if (tap == dbg_pkg::tap_sh_dr)
                  chain[c] <= {tdi_s, chain[c][dbg_pkg::chain_width-1:1]}; // R8
            end
         end
      end
   endgenerate

   // instruction handed to the core pipeline at update, one cycle pulse
   always_ff @(posedge clock)
   begin
      if (rst || debug_reset)
      begin
         core_instr       <= '0;
         core_instr_valid <= 1'b0;
      end
      else
      begin
         core_instr_valid <= tck_rise && emulation_mode && tap == dbg_pkg::tap_upd_dr &&
                             ir == dbg_pkg::ir_intest; // R8
         if (tck_rise && tap == dbg_pkg::tap_upd_dr)
            core_instr <= chain[chain_sel];
      end
   end

   // output bit of the selected register
   always_comb
   begin
      scan_out = bypass_bit;
      if (tap == dbg_pkg::tap_sh_ir)
         scan_out = ir_shift[0];
      else if (emulation_mode && ir != dbg_pkg::ir_bypass)
         scan_out = chain[chain_sel][0]; // R1 R7
      else if (!emulation_mode &&
               (ir == dbg_pkg::ir_sample || ir == dbg_pkg::ir_extest))
         scan_out = bsr[0]; // R16
   end

   // tdo changes on the falling test clock, as the chain expects
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         tdo    <= 1'b0;
         tdo_oe <= 1'b0;
      end
      else if (tck_fall)
      begin
         tdo    <= scan_out; // R7
         tdo_oe <= (tap == dbg_pkg::tap_sh_dr) || (tap == dbg_pkg::tap_sh_ir);
      end
   end

   // returned clock echoes the synchronised test clock in emulation only
   always_ff @(posedge clock)
   begin
      if (rst)
         returned_test_clock <= 1'b0;
      else
         returned_test_clock <= emulation_mode & tck_s; // R6
   end

   // trace unit resources are internal; external pins tied off
   assign unused_trace_io = 1'b0; // R14 R15

   trace_port u_trace (
      .clock           (clock),
      .rst             (rst),
      .status_in       (core_status),
      .packet_in       (core_packet),
      .packet_valid    (core_packet_valid),
      .branch_start    (core_branch_start & ~unused_trace_io),
      .trace_clock     (trace_clock),
      .trace_sync      (trace_sync),
      .pipeline_status (pipeline_status),
      .trace_packet    (trace_packet),
      .sample_edge     (trace_edge)
   );

   returned_test_clock_mode_a: assert property (@(posedge clock) disable iff (rst) // R6
      !emulation_mode |=> !returned_test_clock) else $error("return clock in scan mode");
   mode_hold_a: assert property (@(posedge clock) disable iff (rst) // R2
      (por_count == dbg_pkg::por_width'(dbg_pkg::por_cycles) &&
       $past(por_count) == dbg_pkg::por_width'(dbg_pkg::por_cycles))
      |-> $stable(emulation_mode)) else $error("mode changed without reset");
   por_pulse_a: assert property (@(posedge clock) // R3
      $fell(rst) |-> debug_reset [*4]) else $error("power-on reset too short");
   // the count is registered, so reset shows one edge after the third low sample
   trst_hold_a: assert property (@(posedge clock) disable iff (rst || !trace_edge) // R4
      (!trst_n_s [*3]) |=> debug_reset) else $error("test reset not honoured");
   trst_short_a: assert property (@(posedge clock) disable iff (rst) // R4
      (trst_n_s && por_count == dbg_pkg::por_width'(dbg_pkg::por_cycles)) |=>
      !trst_hit) else $error("reset taken too early");
   emu_route_a: assert property (@(posedge clock) disable iff (rst) // R1
      (emulation_mode && tck_rise) |=> !pin_force_en) else $error("scan active in emulation");
endmodule : debug_trace_port_access

// >>> debug_trace_port_access_bench.sv
// self-checking bench for the debug and trace port logic
module debug_trace_port_access_bench;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clock, rst, scan_mode_select, debug_logic_reset_n, tck, tms, tdi;
   logic        tdo, tdo_oe, returned_test_clock, pin_force_en, core_instr_valid;
   logic        debug_reset, emulation_mode, trace_clock, trace_sync;
   logic        core_branch_start, last_trace_clock, pf, q, d;
   logic [15:0] pin_sample, pin_force, core_packet, trace_packet;
   logic [31:0] core_result, core_instr, w;
   logic [2:0]  core_status, pipeline_status;
   logic [1:0]  core_packet_valid;
   logic [20:0] exp_q[$];
   int          miscompares = 0;
   int          checked = 0;
   int          n;
   int          pulses = 0;

   debug_trace_port_access i_debug_trace_port_access (
      .clock, .rst, .scan_mode_select, .debug_logic_reset_n, .tck, .tms, .tdi,
      .tdo, .tdo_oe, .returned_test_clock, .pin_sample, .pin_force, .pin_force_en,
      .core_result, .core_instr, .core_instr_valid, .core_status, .core_packet,
      .core_packet_valid, .core_branch_start, .debug_reset, .emulation_mode,
      .trace_clock, .trace_sync, .pipeline_status, .trace_packet
   );

   probe_model i_probe_model (
      .clock, .tdo, .tck, .tms, .tdi, .debug_logic_reset_n
   );

   initial
   begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   task check(input logic [31:0] got, input logic [31:0] exp, input string what);
      checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check

   task print_verdict;
      if (miscompares == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : print_verdict

   // bounded wait for a level; n keeps the clocks taken
   task wait_sig(input int sel, input logic lvl, input int lim);
      for (n = 0; n < lim; n++)
      begin
         if ((sel == 0 ? debug_reset : returned_test_clock) === lvl)
            return;
         @(negedge clock);
      end
      check(1'b0, 1'b1, "wait ran out");
      print_verdict();
   endtask : wait_sig

   // bypass holds one stage: tdo shows the bit sent in the same tap step, read after the fall
   task run_bypass;
      i_probe_model.tap_bit(1'b0, 1'b0, q);
      i_probe_model.tap_bit(1'b1, 1'b0, q);
      i_probe_model.tap_bit(1'b0, 1'b0, q);
      i_probe_model.tap_bit(1'b0, 1'b0, q);
      check(q, 1'b0, "bypass capture");
      repeat (8)
      begin
         d = 1'($urandom());
         i_probe_model.tap_bit(1'b0, d, q);
         check(q, d, "bypass shift");
         check(tdo_oe, 1'b1, "tdo enable");
      end
   endtask : run_bypass

   // cnt tap bits, tms and tdi taken lsb first
   task tap_seq(input logic [15:0] m, input logic [15:0] t, input int cnt);
      for (int k = 0; k < cnt; k++)
         i_probe_model.tap_bit(m[k], t[k], q);
   endtask : tap_seq

   // from shift-dr: load code, capture, swap w in while cap comes out, update
   task load_dr(input logic [3:0] code, input int len, input logic [31:0] cap,
                input logic [31:0] wv);
      tap_seq(16'h060f, {6'h00, code, 6'h00}, 12);
      tap_seq(16'h0001, 16'h0000, 3);
      check(q, cap[0], "first captured bit");
      for (int j = 0; j < len; j++)
      begin
         i_probe_model.tap_bit(j == len - 1, wv[j], q);
         if (j < len - 1)
            check(q, cap[j + 1], "captured bit");
      end
      tap_seq(16'h0001, 16'h0000, 2);
   endtask : load_dr

   // scoreboard: every clock after a note takes the oldest one
   always @(posedge clock)
   begin
      #1;
      if (exp_q.size() > 0)
         check({trace_sync, pipeline_status, trace_packet}, exp_q.pop_front(), "trace");
      if (!rst)
         check(trace_clock, !last_trace_clock, "trace clock");
      last_trace_clock = trace_clock;
      if (core_instr_valid)
         pulses++;
   end

   // hang guard far above the expected run time
   initial
   begin
      #1ms;
      miscompares++;
      print_verdict();
   end

   initial
   begin
      void'($urandom(32'h9e8f));
      rst = 1'b1;
      scan_mode_select = 1'b0;
      pin_sample = 16'($urandom());
      core_result = $urandom();
      core_status = 3'h0;
      core_packet = 16'h0000;
      core_packet_valid = 2'h0;
      core_branch_start = 1'b0;
      repeat (8) @(negedge clock);
      rst = 1'b0;
      @(negedge clock);
      check(debug_reset, 1'b1, "power-on hold");
      wait_sig(0, 1'b0, 20);
      check(n < dbg_pkg::por_cycles + 2, 1'b1, "power-on length");
      check(emulation_mode, 1'b1, "emulation mode");
      i_probe_model.set_tck(1'b1);
      check(returned_test_clock, 1'b1, "return clock high");
      i_probe_model.set_tck(1'b0);
      check(returned_test_clock, 1'b0, "return clock low");
      run_bypass();
      w = $urandom();
      load_dr(dbg_pkg::ir_intest, 32, core_result, w);
      check(core_instr, w, "instruction into core");
      check(pulses, 1, "instruction strobe");
      // random trace, 3-bit status so every payload-free code occurs
      repeat (200)
      begin
         @(negedge clock);
         core_status = 3'($urandom());
         core_packet = 16'($urandom());
         core_packet_valid = 2'($urandom());
         core_branch_start = 1'($urandom());
         pf = core_status inside {dbg_pkg::ps_idle, dbg_pkg::ps_cond_fail, dbg_pkg::ps_wait};
         exp_q.push_back({core_branch_start & ~pf, core_status,
            (core_packet_valid[1] & ~pf) ? core_packet[15:8] : 8'h00,
            (core_packet_valid[0] & ~pf) ? core_packet[7:0] : 8'h00});
      end
      @(negedge clock);
      fork
         i_probe_model.hold_trst(8);
         begin
            repeat (7) @(negedge clock);
            check(debug_reset, 1'b1, "test reset");
         end
      join
      wait_sig(0, 1'b0, 10);
      // a live change of mode select must not take effect
      scan_mode_select = 1'b1;
      repeat (6) @(negedge clock);
      check(emulation_mode, 1'b1, "no live switch");
      rst = 1'b1;
      repeat (8) @(negedge clock);
      rst = 1'b0;
      repeat (10) @(negedge clock);
      check(emulation_mode, 1'b0, "scan mode after reset");
      i_probe_model.set_tck(1'b1);
      check(returned_test_clock, 1'b0, "no return clock in scan");
      i_probe_model.set_tck(1'b0);
      run_bypass();
      check(pin_force_en, 1'b0, "no force in bypass");
      w = $urandom();
      load_dr(dbg_pkg::ir_extest, 16, {16'h0000, pin_sample}, w);
      check(pin_force, w[15:0], "extest pin drive");
      check(pin_force_en, 1'b1, "extest enable");
      print_verdict();
   end
endmodule : debug_trace_port_access_bench

// >>> probe_model.sv
// probe and tester model: slow test clock, tap bits and test reset
module probe_model (
   input  wire logic clock,
   input  wire logic tdo,
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   output logic      debug_logic_reset_n
);
   timeunit 1ns;
   timeprecision 1ps;

   // tck stands low outside frames
   initial
   begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
      debug_logic_reset_n = 1'b1;
   end

   // 8 clocks a half period keeps tck far under a sixth of clock
   task set_tck(input logic v);
      tck = v;
      repeat (8) @(negedge clock);
   endtask : set_tck

   // one tap bit; tdo is read once the falling edge has passed
   task tap_bit(input logic m, input logic d, output logic q);
      tms = m;
      tdi = d;
      set_tck(1'b1);
      set_tck(1'b0);
      q = tdo;
   endtask : tap_bit

   // test reset held low for n clocks, n above 2.5
   task hold_trst(input int n);
      debug_logic_reset_n = 1'b0;
      repeat (n) @(negedge clock);
      debug_logic_reset_n = 1'b1;
   endtask : hold_trst
endmodule : probe_model

// >>> sync2.sv
// two flip-flop synchroniser for one level
module sync2 #(
   parameter logic init = 1'b0
) (
   input  wire logic clock,
   input  wire logic rst,
   input  wire logic d,
   output logic      q
);
   logic meta;

   // first stage is read only by the second
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         meta <= init;
         q    <= init;
      end
      else
      begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule : sync2

// >>> trace_port.sv
// half-rate trace output port with status and two packet lanes
module trace_port (
   input  wire logic                               clock,
   input  wire logic                               rst,
   input  wire logic [dbg_pkg::status_width-1:0]   status_in,
   input  wire logic [dbg_pkg::port_width-1:0]     packet_in,
   input  wire logic [dbg_pkg::packets_per_cyc-1:0] packet_valid,
   input  wire logic                               branch_start,
   output logic                                    trace_clock,
   output logic                                    trace_sync,
   output logic [dbg_pkg::status_width-1:0]        pipeline_status,
   output logic [dbg_pkg::port_width-1:0]          trace_packet,
   output logic                                    sample_edge
);
   logic carries_payload;

   // divider: trace_clock flips every processor cycle, half rate
   always_ff @(posedge clock)
   begin
      if (rst)
         trace_clock <= 1'b0;
      else
         trace_clock <= ~trace_clock; // R9
   end

   // every processor edge is a trace clock edge, rising or falling
   assign sample_edge = 1'b1; // R17

   always_comb
   begin
      carries_payload = 1'b1;
      if (status_in == dbg_pkg::ps_cond_fail || status_in == dbg_pkg::ps_wait ||
          status_in == dbg_pkg::ps_idle)
         carries_payload = 1'b0; // R13
   end

   // outputs registered together so status and packets stay aligned
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         pipeline_status <= dbg_pkg::ps_idle;
         trace_sync      <= 1'b0;
         trace_packet    <= '0;
      end
      else
      begin
         pipeline_status <= status_in; // R11 R18
         trace_sync      <= branch_start & carries_payload; // R10
         for (int i = 0; i < int'(dbg_pkg::packets_per_cyc); i++)
            trace_packet[i*dbg_pkg::packet_width +: dbg_pkg::packet_width] <=
               (carries_payload && packet_valid[i]) ?
               packet_in[i*dbg_pkg::packet_width +: dbg_pkg::packet_width] :
               8'h00; // R12 R13
      end
   end

   // first edge after reset has no toggle history, so it is skipped
   trace_clock_a: assert property (@(posedge clock) disable iff (rst) // R9
      !$past(rst) |-> trace_clock != $past(trace_clock))
      else $error("trace clock not half rate");
   no_payload_a: assert property (@(posedge clock) disable iff (rst) // R13
      (status_in == dbg_pkg::ps_cond_fail) |=> (trace_packet == '0))
      else $error("payload beside empty status");
   status_follow_a: assert property (@(posedge clock) disable iff (rst) // R11
      1'b1 |=> (pipeline_status == $past(status_in)))
      else $error("status not forwarded");
   sync_mark_a: assert property (@(posedge clock) disable iff (rst) // R10
      trace_sync |-> $past(branch_start)) else $error("sync without branch");
endmodule : trace_port
